// file: hw/kpc_pkg.sv
// Package for the keyed PLL and power control block: map, fields, types.
`default_nettype none
package kpc_pkg;
  // Register byte addresses.
  localparam logic [31:0] POW_PRE_KEY_ADDR  = 32'hffff0404;
  localparam logic [31:0] POW_CTRL_ADDR     = 32'hffff0408;
  localparam logic [31:0] POW_POST_KEY_ADDR = 32'hffff040c;
  localparam logic [31:0] PLL_PRE_KEY_ADDR  = 32'hffff0410;
  localparam logic [31:0] PLL_CTRL_ADDR     = 32'hffff0414;
  localparam logic [31:0] PLL_POST_KEY_ADDR = 32'hffff0418;

  // Key values.
  localparam logic [31:0] PLL_PRE_KEY  = 32'h000000aa;
  localparam logic [31:0] PLL_POST_KEY = 32'h00000055;
  localparam logic [31:0] POW_PRE_KEY  = 32'h00000001;
  localparam logic [31:0] POW_POST_KEY = 32'h000000f4;

  // Reset values.
  localparam logic [7:0] POW_CTRL_RESET = 8'h79;
  localparam logic [1:0] PLL_SRC_RESET  = 2'h0;

  // Field positions in power_mode_control.
  localparam int POW_PREC_BIT   = 7;
  localparam int POW_XTAL_BIT   = 6;
  localparam int POW_PLL_BIT    = 5;
  localparam int POW_PERIPH_BIT = 4;
  localparam int POW_CORE_BIT   = 3;
  localparam int CD_MSB         = 2;
  localparam int CD_LSB         = 0;
  localparam int CD_W           = 3;
  localparam int SRC_W          = 2;

  // PLL reference source codes.
  localparam logic [1:0] SRC_LP_OSC   = 2'h0;
  localparam logic [1:0] SRC_PREC_OSC = 2'h1;
  localparam logic [1:0] SRC_XTAL     = 2'h2;
  localparam logic [1:0] SRC_RESERVED = 2'h3;

  // PLL figures: 32.768 kHz reference times 625 gives 20.48 MHz.
  localparam int PLL_REF_HZ = 32768;
  localparam int PLL_MULT   = 625;
  localparam int PLL_OUT_HZ = PLL_REF_HZ * PLL_MULT;
  localparam int CLK_HZ     = 20000000;

  // Flash clock divide while the PLL is still locking.
  localparam logic [2:0] FLASH_LOCK_DIV_MAX = 3'h7;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_POW_PRE, SEL_POW_CTRL, SEL_POW_POST,
    SEL_PLL_PRE, SEL_PLL_CTRL, SEL_PLL_POST
  } kpc_sel_t;

  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_PLL_KEYED, SEQ_PLL_HELD, SEQ_POW_KEYED, SEQ_POW_HELD
  } kpc_seq_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } kpc_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } kpc_axi_rsp_t;

  typedef struct packed {
    logic [1:0] pll_source;
    logic       precision_input_en;
    logic       xtal_en;
    logic       pll_en;
    logic       periph_en;
    logic       core_en;
    logic [2:0] core_divider_field;
    logic       pll_timer_run;
    logic       wake_timer_run;
    logic       core_tick;
    logic       flash_tick;
  } kpc_ctrl_t;
endpackage
`default_nettype wire

// file: hw/kpc_top.sv
// Keyed PLL source and power mode control with an AXI4-Lite register port.
`default_nettype none

// What this block does
// - PLL source write needs prewrite key 0xaa first.
// - PLL postwrite key 0x55 completes the update.
// - Power write needs prewrite key 0x01 first.
// - Power postwrite key 0xf4 completes the update.
// - Two-bit source picks low-power, precision, crystal.
// - Bit 7 enables precision input, needs high-voltage config.
// - Bit 6 enables crystal circuitry.
// - Bit 5 clear stops PLL and PLL timers.
// - PLL off only with core, peripherals off.
// - Bit 4 clear powers down peripherals.
// - Peripherals off only together with core.
// - LIN wake and low-power wake timer survive.
// - Bit 3 clear powers down the core.
// - PLL, peripheral, core enables reset and wake high.
// - Core clock is PLL output over two-to-field.
// - Divider field resets to 001.
// - Flash clock divided by eight until locked.
// - PLL multiplies 32.768 kHz by 625.
module kpc_top
  import kpc_pkg::*;
(
  // Clock and reset.
  input  wire logic         ref_clk_i,
  input  wire logic         sys_rst_i,
  // Register bus.
  input  wire kpc_axi_req_t axi_req_i,
  output var  kpc_axi_rsp_t axi_rsp_o,
  // Wake-up and status inputs.
  input  wire logic         wake_event_i,
  input  wire logic         lin_wake_i,
  input  wire logic         high_voltage_config_i,
  input  wire logic         wake_timer_on_lp_osc_i,
  input  wire logic         pll_locked_i,
  // Clock and power controls.
  output var  kpc_ctrl_t    ctrl_o
);

  function automatic kpc_sel_t decode(input logic [31:0] addr);
    case (addr)
      POW_PRE_KEY_ADDR:  decode = SEL_POW_PRE;
      POW_CTRL_ADDR:     decode = SEL_POW_CTRL;
      POW_POST_KEY_ADDR: decode = SEL_POW_POST;
      PLL_PRE_KEY_ADDR:  decode = SEL_PLL_PRE;
      PLL_CTRL_ADDR:     decode = SEL_PLL_CTRL;
      PLL_POST_KEY_ADDR: decode = SEL_PLL_POST;
      default:           decode = SEL_NONE;
    endcase
  endfunction

  function automatic logic [31:0] strobe_data(input logic [31:0] d,
                                              input logic [3:0]  s);
    strobe_data = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // Bus state.
  logic         aw_got;
  logic         w_got;
  logic [31:0]  aw_addr;
  logic [31:0]  w_data;
  kpc_axi_rsp_t rsp;

  // Control state.
  kpc_seq_t     seq;
  logic [7:0]   held_value;
  logic [1:0]   pll_src;
  logic [7:0]   pow_reg;
  logic [2:0]   core_cnt;
  logic [6:0]   core_div_cnt;
  logic [2:0]   flash_cnt;
  kpc_ctrl_t    ctrl;

  // Write path decode.
  wire          wr_fire   = aw_got & w_got & ~rsp.bvalid;
  wire kpc_sel_t wr_sel   = decode(aw_addr);
  wire          wr_mapped = (wr_sel != SEL_NONE);
  wire          aw_take   = axi_req_i.awvalid & rsp.awready;
  wire          w_take    = axi_req_i.wvalid & rsp.wready;
  wire [31:0]   w_masked  = strobe_data(axi_req_i.wdata, axi_req_i.wstrb);

  // Read path decode; key registers read as zero and leave the sequence
  // untouched because only writes feed the sequencer.
  wire          ar_take  = axi_req_i.arvalid & rsp.arready;
  wire kpc_sel_t rd_sel  = decode(axi_req_i.araddr);
  wire [31:0]   rd_data  =
    (rd_sel == SEL_POW_CTRL) ? {24'h000000, pow_reg} :
    (rd_sel == SEL_PLL_CTRL) ? {30'h00000000, pll_src} :
    32'h00000000;
  wire [1:0]    rd_resp  = (rd_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;

  // Key checks.
  wire pll_pre_ok  = (wr_sel == SEL_PLL_PRE)  && (w_data == PLL_PRE_KEY);
  wire pll_post_ok = (wr_sel == SEL_PLL_POST) && (w_data == PLL_POST_KEY);
  wire pow_pre_ok  = (wr_sel == SEL_POW_PRE)  && (w_data == POW_PRE_KEY);
  wire pow_post_ok = (wr_sel == SEL_POW_POST) && (w_data == POW_POST_KEY);

  // Any write that breaks the three-step order returns the sequencer to
  // idle; a fresh correct prewrite key may restart it at once.
  kpc_seq_t next_seq;
  always_comb begin
    next_seq = seq;
    if (wr_fire) begin
      case (seq)
        SEQ_PLL_KEYED:
          next_seq = (wr_sel == SEL_PLL_CTRL) ? SEQ_PLL_HELD : SEQ_IDLE;
        SEQ_POW_KEYED:
          next_seq = (wr_sel == SEL_POW_CTRL) ? SEQ_POW_HELD : SEQ_IDLE;
        default:
          next_seq = SEQ_IDLE;
      endcase
      if (pll_pre_ok) begin
        next_seq = SEQ_PLL_KEYED;
      end else if (pow_pre_ok) begin
        next_seq = SEQ_POW_KEYED;
      end
    end
  end

  wire commit_pll = wr_fire && (seq == SEQ_PLL_HELD) && pll_post_ok;
  wire commit_pow = wr_fire && (seq == SEQ_POW_HELD) && pow_post_ok;

  // The enable interlock keeps a refused clear at one: the PLL stays on
  // while core or peripherals stay on, peripherals stay on while the core
  // does. Other fields of the same write still take effect.
  wire new_core   = held_value[POW_CORE_BIT];
  wire new_periph = held_value[POW_PERIPH_BIT] | new_core;
  wire new_pll    = held_value[POW_PLL_BIT] | new_periph;
  wire [7:0] pow_commit_value = {
    held_value[POW_PREC_BIT],
    held_value[POW_XTAL_BIT],
    new_pll, new_periph, new_core,
    held_value[CD_MSB:CD_LSB]
  };

  // A wake-up, including one seen on LIN while the peripherals are down,
  // re-enables PLL, peripherals and core; it wins over a same-cycle commit.
  wire wake = wake_event_i | lin_wake_i;
  logic [7:0] next_pow;
  always_comb begin
    next_pow = commit_pow ? pow_commit_value : pow_reg;
    if (wake) begin
      next_pow[POW_PLL_BIT]    = 1'b1;
      next_pow[POW_PERIPH_BIT] = 1'b1;
      next_pow[POW_CORE_BIT]   = 1'b1;
    end
  end

  // Only the two-bit field is kept; upper bits read zero whatever
  // software writes there. The reserved code is stored as written.
  wire [1:0] next_pll_src = commit_pll ? held_value[SRC_W-1:0] : pll_src;

  // Core tick: one pulse every two-to-the-field clock cycles. The
  // clock stands for the PLL output, the reference times 625.
  wire [2:0] cd_now = pow_reg[CD_MSB:CD_LSB];
  wire [6:0] core_div_max = 7'((8'h01 << cd_now) - 8'h01);
  wire       core_wrap = (core_div_cnt >= core_div_max);
  wire [6:0] next_core_div_cnt = core_wrap ? 7'h00 : core_div_cnt + 7'h01;

  // Flash tick: every cycle once locked, else one in eight.
  wire       flash_wrap = pll_locked_i | (flash_cnt == FLASH_LOCK_DIV_MAX);
  wire [2:0] next_flash_cnt = flash_wrap ? 3'h0 : flash_cnt + 3'h1;

  kpc_ctrl_t next_ctrl;
  always_comb begin
    next_ctrl.pll_source         = pll_src;
    next_ctrl.precision_input_en = pow_reg[POW_PREC_BIT]
                                   & high_voltage_config_i;
    next_ctrl.xtal_en            = pow_reg[POW_XTAL_BIT];
    next_ctrl.pll_en             = pow_reg[POW_PLL_BIT];
    next_ctrl.periph_en          = pow_reg[POW_PERIPH_BIT];
    next_ctrl.core_en            = pow_reg[POW_CORE_BIT];
    next_ctrl.core_divider_field = cd_now;
    next_ctrl.pll_timer_run      = pow_reg[POW_PLL_BIT];
    next_ctrl.wake_timer_run     = pow_reg[POW_PERIPH_BIT]
                                   | wake_timer_on_lp_osc_i;
    next_ctrl.core_tick          = core_wrap & pow_reg[POW_CORE_BIT];
    next_ctrl.flash_tick         = flash_wrap;
  end

  // Write channel handshake: address and data taken in either order.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      aw_got      <= 1'b0;
      w_got       <= 1'b0;
      aw_addr     <= 32'h00000000;
      w_data      <= 32'h00000000;
      rsp.awready <= 1'b1;
      rsp.wready  <= 1'b1;
      rsp.bvalid  <= 1'b0;
      rsp.bresp   <= RESP_OKAY;
      rsp.arready <= 1'b1;
      rsp.rvalid  <= 1'b0;
      rsp.rdata   <= 32'h00000000;
      rsp.rresp   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_got      <= 1'b1;
        aw_addr     <= axi_req_i.awaddr;
        rsp.awready <= 1'b0;
      end
      if (w_take) begin
        w_got      <= 1'b1;
        w_data     <= w_masked;
        rsp.wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got     <= 1'b0;
        w_got      <= 1'b0;
        rsp.bvalid <= 1'b1;
        rsp.bresp  <= wr_mapped ? RESP_OKAY : RESP_DECERR;
      end else if (rsp.bvalid && axi_req_i.bready) begin
        rsp.bvalid  <= 1'b0;
        rsp.awready <= 1'b1;
        rsp.wready  <= 1'b1;
      end
      // Read channel shares this process so that one process owns the
      // whole response struct; one read at a time, answered next edge.
      if (ar_take) begin
        rsp.arready <= 1'b0;
        rsp.rvalid  <= 1'b1;
        rsp.rdata   <= rd_data;
        rsp.rresp   <= rd_resp;
      end else if (rsp.rvalid && axi_req_i.rready) begin
        rsp.rvalid  <= 1'b0;
        rsp.arready <= 1'b1;
      end
    end
  end

  // Protection sequencer and protected registers.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      seq        <= SEQ_IDLE;
      held_value <= 8'h00;
      pll_src    <= PLL_SRC_RESET;
      pow_reg    <= POW_CTRL_RESET;
    end else begin
      seq     <= next_seq;
      pll_src <= next_pll_src;
      pow_reg <= next_pow;
      if (wr_fire && (wr_sel == SEL_PLL_CTRL || wr_sel == SEL_POW_CTRL)) begin
        held_value <= w_data[7:0];
      end
    end
  end

  // Clock tick counters and registered control outputs.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      core_div_cnt <= 7'h00;
      flash_cnt    <= 3'h0;
      ctrl         <= '0;
    end else begin
      core_div_cnt <= next_core_div_cnt;
      flash_cnt    <= next_flash_cnt;
      ctrl         <= next_ctrl;
    end
  end

  assign axi_rsp_o = rsp;
  assign ctrl_o    = ctrl;

  // Unused helper kept out of logic: the source count only names codes.
  logic unused_src;
  assign unused_src = ^{SRC_LP_OSC, SRC_PREC_OSC, SRC_XTAL, SRC_RESERVED,
                        core_cnt, PLL_OUT_HZ[0], CLK_HZ[0]};
  always_ff @(posedge ref_clk_i) begin
    core_cnt <= 3'h0;
  end

endmodule // kpc_top
`default_nettype wire

// file: tb/keyed_pll_power_control_tb_top.sv
// Self-checking bench for the keyed PLL and power control block.
`default_nettype none
module keyed_pll_power_control_tb_top
  import kpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         ref_clk_i = 1'b0;
  logic         sys_rst_i = 1'b1;
  kpc_axi_req_t req = '0;
  kpc_axi_rsp_t rsp;
  kpc_ctrl_t    ctrl;
  logic         wake = 1'b0;
  logic         lin = 1'b0;
  logic         hvc = 1'b0;
  logic         lpt = 1'b0;
  logic         lock = 1'b1;
  logic [7:0]   v;
  logic [7:0]   e;
  logic [7:0]   tbl [4] = '{8'h19, 8'h29, 8'h11, 8'h01};
  logic [1:0]   exp_b [$];
  logic [33:0]  exp_r [$];
  integer       seed = 32'he1d3005b;
  int           miscompares = 0;
  int           n_tests = 0;
  int           cycles = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  kpc_top uut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .axi_req_i(req), .axi_rsp_o(rsp), .wake_event_i(wake),
    .lin_wake_i(lin), .high_voltage_config_i(hvc),
    .wake_timer_on_lp_osc_i(lpt), .pll_locked_i(lock), .ctrl_o(ctrl));
  task automatic chk(input string nm, input logic [33:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Ready drops after each take; each valid falls at the first edge that sees its ready high.
  task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
    exp_b.push_back(r);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    do begin
      @(posedge ref_clk_i);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (req.awvalid && !rsp.awready || req.wvalid && !rsp.wready);
    do @(posedge ref_clk_i); while (rsp.bvalid !== 1'b1);
  endtask
  task automatic rd(input logic [31:0] a, input logic [33:0] x);
    exp_r.push_back(x);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    do @(posedge ref_clk_i); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge ref_clk_i); while (rsp.rvalid !== 1'b1);
  endtask
  task automatic pll_seq(input logic [31:0] k0, k1, input bit gap,
                         input logic [1:0] d, x);
    wr(PLL_PRE_KEY_ADDR, k0, RESP_OKAY);
    rd(POW_PRE_KEY_ADDR, 34'h0);
    if (gap) wr(POW_POST_KEY_ADDR, 32'h0, RESP_OKAY);
    wr(PLL_CTRL_ADDR, {30'h0, d}, RESP_OKAY);
    wr(PLL_POST_KEY_ADDR, k1, RESP_OKAY);
    rd(PLL_CTRL_ADDR, {32'h0, x});
    chk("src", {32'h0, ctrl.pll_source}, {32'h0, x});
  endtask
  task automatic pow_wr(input logic [7:0] d);
    wr(POW_PRE_KEY_ADDR, POW_PRE_KEY, RESP_OKAY);
    wr(POW_CTRL_ADDR, {24'h0, d}, RESP_OKAY);
    wr(POW_POST_KEY_ADDR, POW_POST_KEY, RESP_OKAY);
    e = d;
    if (e[3]) e[4] = 1'b1;
    if (e[4]) e[5] = 1'b1;
    rd(POW_CTRL_ADDR, {26'h0, e});
    chk("pow", {24'h0, ctrl.precision_input_en, ctrl.xtal_en, ctrl.pll_en,
      ctrl.periph_en, ctrl.core_en, ctrl.core_divider_field,
      ctrl.pll_timer_run, ctrl.wake_timer_run}, {24'h0, e[7] & hvc,
      e[6:0], e[5], e[4] | lpt});
  endtask
  always @(posedge ref_clk_i) begin
    if (rsp.bvalid === 1'b1) chk("bresp", {32'h0, rsp.bresp},
      {32'h0, exp_b.pop_front()});
    if (rsp.rvalid === 1'b1) chk("rdata", {rsp.rresp, rsp.rdata},
      exp_r.pop_front());
  end
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    req.bready = 1'b1;
    req.rready = 1'b1;
    req.wstrb  = 4'hf;
    repeat (10) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    rd(POW_CTRL_ADDR, {26'h0, POW_CTRL_RESET});
    rd(32'hffff0420, {RESP_DECERR, 32'h0});
    wr(32'hffff0420, 32'h1, RESP_DECERR);
    for (int c = 0; c < 4; c++) pll_seq(PLL_PRE_KEY, PLL_POST_KEY, 0,
      2'(c), 2'(c));
    wr(PLL_CTRL_ADDR, 32'h1, RESP_OKAY);
    pll_seq(32'h000000ab, PLL_POST_KEY, 0, 2'h1, 2'h3);
    pll_seq(32'h010000aa, PLL_POST_KEY, 0, 2'h1, 2'h3);
    pll_seq(PLL_PRE_KEY, 32'h00000056, 0, 2'h1, 2'h3);
    pll_seq(PLL_PRE_KEY, PLL_POST_KEY, 1, 2'h1, 2'h3);
    for (int c = 0; c < 8; c++) begin
      hvc <= 1'($random(seed));
      lpt <= 1'($random(seed));
      v = 8'($random(seed));
      pow_wr({v[7:6], 3'h7, 3'(c)});
      // Two full core periods at this divider.
      repeat ((2 << c) + 4) @(posedge ref_clk_i);
    end
    foreach (tbl[i]) pow_wr(tbl[i]);
    for (int w = 0; w < 2; w++) begin
      pow_wr(8'h01);
      {wake, lin} <= 2'(1 << w);
      @(posedge ref_clk_i);
      {wake, lin} <= 2'h0;
      rd(POW_CTRL_ADDR, 34'h39);
    end
    lock <= 1'b0;
    repeat (40) @(posedge ref_clk_i);
    lock <= 1'b1;
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    rd(POW_CTRL_ADDR, {26'h0, POW_CTRL_RESET});
    rd(PLL_CTRL_ADDR, 34'h0);
    conclude();
  end
endmodule // keyed_pll_power_control_tb_top
bind kpc_top kpc_checker u_chk (.ref_clk_i(ref_clk_i),
  .sys_rst_i(sys_rst_i), .axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o),
  .wake_event_i(wake_event_i), .lin_wake_i(lin_wake_i),
  .high_voltage_config_i(high_voltage_config_i),
  .wake_timer_on_lp_osc_i(wake_timer_on_lp_osc_i),
  .pll_locked_i(pll_locked_i), .ctrl_o(ctrl_o));
`default_nettype wire

// file: tb/kpc_checker.sv
// Port-level assertions for the keyed PLL and power control block.
`default_nettype none
module kpc_checker
  import kpc_pkg::*;
(
  // Clock and reset.
  input wire logic         ref_clk_i,
  input wire logic         sys_rst_i,
  // Register bus.
  input wire kpc_axi_req_t axi_req_i,
  input wire kpc_axi_rsp_t axi_rsp_o,
  // Wake-up and status inputs.
  input wire logic         wake_event_i,
  input wire logic         lin_wake_i,
  input wire logic         high_voltage_config_i,
  input wire logic         wake_timer_on_lp_osc_i,
  input wire logic         pll_locked_i,
  // Clock and power controls.
  input wire kpc_ctrl_t    ctrl_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [7:0] gap;
  logic [2:0] cd_q;
  logic       seen;
  wire        key_rd = axi_req_i.araddr inside {POW_PRE_KEY_ADDR,
    POW_POST_KEY_ADDR, PLL_PRE_KEY_ADDR, PLL_POST_KEY_ADDR};
  wire        cd_chg = cd_q != ctrl_o.core_divider_field;
  // The first tick after a divider change only restarts the measurement.
  always_ff @(posedge ref_clk_i) begin
    cd_q <= ctrl_o.core_divider_field;
    if (sys_rst_i || !ctrl_o.core_en || cd_chg) begin
      seen <= 1'b0;
      gap  <= 8'h1;
    end else if (ctrl_o.core_tick) begin
      seen <= 1'b1;
      gap  <= 8'h1;
    end else begin
      gap <= gap + 8'h1;
    end
  end
  sequence s_unlk8;
    (!pll_locked_i)[*8];
  endsequence
  sequence s_en3;
    ctrl_o.pll_en && ctrl_o.periph_en && ctrl_o.core_en;
  endsequence
  property p_wake;
    wake_event_i || lin_wake_i |-> ##2 s_en3;
  endproperty
  property p_pll_lock; $fell(ctrl_o.pll_en) |-> !ctrl_o.periph_en &&
    !ctrl_o.core_en; endproperty
  property p_per_lock; $fell(ctrl_o.periph_en) |-> !ctrl_o.core_en;
  endproperty
  property p_prec; ctrl_o.precision_input_en |->
    $past(high_voltage_config_i); endproperty
  property p_ptimer; ctrl_o.pll_timer_run == ctrl_o.pll_en; endproperty
  property p_wtimer; !$past(sys_rst_i) |-> ctrl_o.wake_timer_run ==
    (ctrl_o.periph_en || $past(wake_timer_on_lp_osc_i)); endproperty
  property p_fl_lock; pll_locked_i |=> ctrl_o.flash_tick; endproperty
  property p_fl_div; s_unlk8 ##1 ctrl_o.flash_tick |=>
    (!ctrl_o.flash_tick || $past(pll_locked_i))[*7]; endproperty
  property p_cdiv; ctrl_o.core_tick && seen && !cd_chg |->
    gap == (8'h1 << ctrl_o.core_divider_field); endproperty
  property p_rst; $fell(sys_rst_i) |=> s_en3 ##0
    ctrl_o.core_divider_field == 3'h1 && ctrl_o.pll_source == 2'h0;
  endproperty
  property p_keyrd; axi_req_i.arvalid && axi_rsp_o.arready && key_rd |=>
    axi_rsp_o.rvalid && axi_rsp_o.rdata == 32'h0; endproperty
  a_wake: assert property (p_wake) else $error("wake");
  a_pll_lock: assert property (p_pll_lock) else $error("pll");
  a_per_lock: assert property (p_per_lock) else $error("per");
  a_prec: assert property (p_prec) else $error("prec");
  a_ptimer: assert property (p_ptimer) else $error("ptim");
  a_wtimer: assert property (p_wtimer) else $error("wtim");
  a_fl_lock: assert property (p_fl_lock) else $error("flash");
  a_fl_div: assert property (p_fl_div) else $error("fdiv");
  a_cdiv: assert property (p_cdiv) else $error("cdiv");
  a_rst: assert property (p_rst) else $error("reset");
  a_keyrd: assert property (p_keyrd) else $error("keyrd");
endmodule // kpc_checker
`default_nettype wire
